// ===== design/ext_bus_pkg.sv
// package: constants and carriers for the external bus space/strobe control
package ext_bus_pkg;

  // ---------------------------------------------------------------
  // widths and address map
  // ---------------------------------------------------------------
  localparam int          ADDR_W      = 23;
  localparam int          ROM_WORDS   = 16384;            // 16K words of on-chip ROM
  localparam logic [22:0] ROM_BASE    = 23'h00C000;       // top 16K of the base page
  localparam logic [22:0] ROM_LAST    = 23'h00FFFF;
  localparam logic        MODE_MCOMP  = 1'b0;             // pin low: ROM mapped in
  localparam int          SYNC_STAGES = 3;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [2:0]  SEL_IDLE    = 3'h7;             // all selects high
  localparam logic        STB_IDLE    = 1'b1;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SPACE_PROG = 3'b001,
    SPACE_DATA = 3'b010,
    SPACE_IO   = 3'b100
  } space_e;

  // access request from the core, level for the whole address phase
  typedef struct packed {
    logic              valid;   // address phase active
    space_e            space;
    logic              strobe;  // strobe phase inside the address phase
    logic [ADDR_W-1:0] addr;
  } access_s;

  // registered control pins, all active low
  typedef struct packed {
    logic program_space_select_n;
    logic data_space_select_n;
    logic io_space_select_n;
    logic memory_strobe_n;
    logic io_strobe_n;
  } bus_ctrl_s;

endpackage : ext_bus_pkg

// ===== design/ext_bus_space_strobe_ctrl.sv
// module: space selects, strobes and ROM mapping mode of the external bus
//
// Overview of operation
// - pin low at reset selects microcomputer mode, ROM in top 16K of the base page
// - microprocessor mode removes ROM, those addresses go to external program memory
// - mode pin is captured only during reset, later changes ignored
// - software mode bit in status register overrides captured mode and steers ROM map
// - space selects idle high, one driven low only for its external space
// - asserted select stays low exactly while the address is valid
// - selects float in hold mode and whenever float pin is low
// - memory strobe idles high, low only for external program/data access
// - memory strobe floats in hold mode and whenever float pin is low
// - I/O accesses use a separate I/O strobe, idle high
`timescale 1ns/1ps
module ext_bus_space_strobe_ctrl (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      srst,
  // pins from outside
  input  wire logic                      proc_mode_select_pin,
  input  wire logic                      off_n_pin,
  // core side
  input  wire ext_bus_pkg::access_s      acc,
  input  wire logic                      hold_mode,
  input  wire logic                      processor_mode_status_reg_wr,
  input  wire logic                      processor_mode_status_reg_mode_wdata,
  output logic                           processor_mode_status_reg,
  output logic                           rom_hit,
  // external bus pins
  output ext_bus_pkg::bus_ctrl_s         ctrl_out,
  output logic                           sel_oe,
  output logic                           stb_oe,
  output logic [ext_bus_pkg::ADDR_W-1:0] addr_out,
  output logic                           addr_valid
);
  import ext_bus_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // active-low select pattern for a space, all high when idle
  function automatic logic [2:0] sel_decode(input logic go, input space_e sp);
    sel_decode = go ? ~sp : SEL_IDLE;
  endfunction : sel_decode

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [SYNC_STAGES-1:0] mode_sync;
  logic [SYNC_STAGES-1:0] off_sync;
  logic                   off_n_reg;

  // no reset here: the mode pin must keep flowing while reset is held
  always_ff @(posedge clk) begin
    mode_sync <= {mode_sync[SYNC_STAGES-2:0], proc_mode_select_pin};
    off_sync  <= {off_sync[SYNC_STAGES-2:0], off_n_pin};
  end

  // float pin counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (srst) begin
      off_n_reg <= 1'b1;
    end else if (off_sync[1] == off_sync[2]) begin
      off_n_reg <= off_sync[2];
    end
  end

  // ---------------------------------------------------------------
  // processor mode
  // ---------------------------------------------------------------
  // pin is taken only while reset is high; hold reset at least 4 edges
  always_ff @(posedge clk) begin
    if (srst) begin
      if (mode_sync[1] == mode_sync[2]) begin
        processor_mode_status_reg <= mode_sync[2];
      end
    end else if (processor_mode_status_reg_wr) begin
      processor_mode_status_reg <= processor_mode_status_reg_mode_wdata;
    end
  end

  // ---------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------
  logic in_rom_range;
  logic external;

  assign in_rom_range = (acc.addr >= ROM_BASE) && (acc.addr <= ROM_LAST);
  // ROM only hides program fetches in microcomputer mode
  assign rom_hit  = acc.valid && (acc.space == SPACE_PROG) && in_rom_range
                    && (processor_mode_status_reg == MODE_MCOMP);
  assign external = acc.valid && !rom_hit && !hold_mode;

  // ---------------------------------------------------------------
  // registered bus pins
  // ---------------------------------------------------------------
  // active-low pin registers; ctrl_out is only a view of them, so that
  // every field has exactly one driving process
  logic [2:0] sel_reg;   // {io, data, program} selects
  logic [1:0] stb_reg;   // {memory, io} strobes

  // selects and address move in the same edge so they frame each other
  always_ff @(posedge clk) begin
    if (srst) begin
      sel_reg    <= SEL_IDLE;
      addr_valid <= 1'b0;
      addr_out   <= '0;
    end else begin
      // the one-hot space code gives a single low select
      sel_reg    <= sel_decode(external, acc.space);
      addr_valid <= external;
      // address is held after the access so the bus does not toggle needlessly
      if (external) begin
        addr_out <= acc.addr;
      end
    end
  end

  // strobes: memory for program/data, separate one for I/O
  always_ff @(posedge clk) begin
    if (srst) begin
      stb_reg <= {STB_IDLE, STB_IDLE};
    end else begin
      stb_reg[1] <= !(external && acc.strobe && (acc.space != SPACE_IO));
      stb_reg[0] <= !(external && acc.strobe && (acc.space == SPACE_IO));
    end
  end

  // pin view of the registers, no logic between flop and pin
  assign ctrl_out = {sel_reg[0], sel_reg[1], sel_reg[2], stb_reg[1], stb_reg[0]};

  // float in hold or with float pin low; enables stay combinational
  assign sel_oe = !hold_mode && off_n_reg;
  assign stb_oe = !hold_mode && off_n_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // all checks are off while reset is high: the pin capture and the reset
  // values are judged by the bench instead, since the mode bit may be
  // unknown for the first few reset edges until the synchroniser fills
  logic [2:0] sel_vec;
  assign sel_vec = {ctrl_out.io_space_select_n, ctrl_out.data_space_select_n,
                    ctrl_out.program_space_select_n};

  rom_hidden_a: assert property (@(posedge clk) disable iff (srst)
    acc.valid && acc.space == SPACE_PROG && in_rom_range
    && processor_mode_status_reg == MODE_MCOMP |=> ctrl_out.program_space_select_n)
    else $error("program select driven for on-chip rom");

  rom_external_a: assert property (@(posedge clk) disable iff (srst)
    acc.valid && !hold_mode && acc.space == SPACE_PROG
    && processor_mode_status_reg != MODE_MCOMP |=> !ctrl_out.program_space_select_n)
    else $error("rom range not sent to external program memory");

  mode_pin_ignored_a: assert property (@(posedge clk) disable iff (srst)
    !processor_mode_status_reg_wr |=> $stable(processor_mode_status_reg))
    else $error("mode changed without a software write");

  mode_write_a: assert property (@(posedge clk) disable iff (srst)
    processor_mode_status_reg_wr |=> processor_mode_status_reg == $past(processor_mode_status_reg_mode_wdata))
    else $error("mode bit write not taken");

  select_idle_a: assert property (@(posedge clk) disable iff (srst)
    !acc.valid |=> sel_vec == SEL_IDLE)
    else $error("select low without an access");

  select_frame_a: assert property (@(posedge clk) disable iff (srst)
    external ##1 !external |-> (sel_vec != SEL_IDLE)
      ##1 ((sel_vec == SEL_IDLE) && !addr_valid))
    else $error("select not aligned to address valid");

  addr_hold_a: assert property (@(posedge clk) disable iff (srst)
    external |=> addr_valid && (addr_out == $past(acc.addr)))
    else $error("address not presented with its select");

  rom_quiet_a: assert property (@(posedge clk) disable iff (srst)
    rom_hit |=> !addr_valid && (sel_vec == SEL_IDLE))
    else $error("bus moved for an on-chip rom fetch");

  select_addr_a: assert property (@(posedge clk) disable iff (srst)
    (sel_vec != SEL_IDLE) == addr_valid)
    else $error("select and address valid disagree");

  select_float_a: assert property (@(posedge clk) disable iff (srst)
    off_sync[2:1] == 2'b00 |=> !sel_oe)
    else $error("selects driven with float pin low");

  select_hold_a: assert property (@(posedge clk) disable iff (srst)
    hold_mode |-> !sel_oe ##1 (sel_vec == SEL_IDLE))
    else $error("selects driven in hold");

  float_release_a: assert property (@(posedge clk) disable iff (srst)
    off_sync[2:1] == 2'b11 && !hold_mode ##1 !hold_mode |-> sel_oe && stb_oe)
    else $error("pins still floating after float pin released");

  memory_strobe_n_space_a: assert property (@(posedge clk) disable iff (srst)
    !ctrl_out.memory_strobe_n |-> $past(acc.space) != SPACE_IO && addr_valid)
    else $error("memory strobe outside a memory access");

  strobe_float_a: assert property (@(posedge clk) disable iff (srst)
    off_sync[2:1] == 2'b00 |=> !stb_oe)
    else $error("strobe driven with float pin low");

  strobe_hold_a: assert property (@(posedge clk) disable iff (srst)
    hold_mode |-> !stb_oe ##1 (ctrl_out.memory_strobe_n && ctrl_out.io_strobe_n))
    else $error("strobe driven in hold");

  memory_strobe_n_select_a: assert property (@(posedge clk) disable iff (srst)
    !ctrl_out.memory_strobe_n |->
      !ctrl_out.program_space_select_n || !ctrl_out.data_space_select_n)
    else $error("memory strobe without a memory select");

  io_strobe_n_origin_a: assert property (@(posedge clk) disable iff (srst)
    !ctrl_out.io_strobe_n |-> $past(acc.space) == SPACE_IO && $past(acc.strobe))
    else $error("io strobe without an io strobe request");

  io_strobe_n_space_a: assert property (@(posedge clk) disable iff (srst)
    !ctrl_out.io_strobe_n |-> !ctrl_out.io_space_select_n && ctrl_out.memory_strobe_n)
    else $error("io strobe without io select");

  one_select_a: assert property (@(posedge clk) disable iff (srst)
    $countones(~sel_vec) <= 1)
    else $error("more than one space select low");

endmodule : ext_bus_space_strobe_ctrl

// ===== verif/ext_bus_mem_model.sv
// partner: external memory and i/o device that count strobed accesses
`timescale 1ns/1ps
module ext_bus_mem_model (
  // bus side
  input  wire logic                  clk,
  input  wire ext_bus_pkg::bus_ctrl_s ctrl,
  input  wire logic                  stb_oe,
  // access counts
  output int                         mem_hits,
  output int                         io_hits
);
  import ext_bus_pkg::*;
  // a floated strobe is not an access, so only driven low cycles count
  initial begin
    mem_hits = 0;
    io_hits  = 0;
  end
  always @(posedge clk) begin
    if (stb_oe && ctrl.memory_strobe_n === 1'b0) mem_hits <= mem_hits + 1;
    if (stb_oe && ctrl.io_strobe_n === 1'b0) io_hits <= io_hits + 1;
  end
endmodule : ext_bus_mem_model

// ===== verif/ext_bus_space_strobe_ctrl_bench.sv
// bench: directed scenarios for the external bus space and strobe control
`timescale 1ns/1ps
module ext_bus_space_strobe_ctrl_bench;
  import ext_bus_pkg::*;
  logic              clk, srst, mode_pin, off_n, hold, wr, wdata;
  logic              mode_reg, rom_hit, sel_oe, stb_oe, addr_valid;
  access_s           acc;
  bus_ctrl_s         ctrl;
  logic [ADDR_W-1:0] addr_out;
  int                mem_hits, io_hits, errors, check_count;
  ext_bus_space_strobe_ctrl u_dut (.clk(clk), .srst(srst), .proc_mode_select_pin(mode_pin),
    .off_n_pin(off_n), .acc(acc), .hold_mode(hold), .processor_mode_status_reg_wr(wr), .processor_mode_status_reg_mode_wdata(wdata),
    .processor_mode_status_reg(mode_reg), .rom_hit(rom_hit), .ctrl_out(ctrl),
    .sel_oe(sel_oe), .stb_oe(stb_oe), .addr_out(addr_out), .addr_valid(addr_valid));
  ext_bus_mem_model u_mem (.clk(clk), .ctrl(ctrl), .stb_oe(stb_oe),
    .mem_hits(mem_hits), .io_hits(io_hits));
  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  // one access: address phase, strobe phase, release; 1F expects a refusal
  task automatic bus_access(input space_e sp, input logic [22:0] a,
                            input logic [4:0] sel_exp, input logic [4:0] stb_exp);
    @(negedge clk);
    acc = '{valid: 1'b1, space: sp, strobe: 1'b0, addr: a};
    @(negedge clk);
    chk(ctrl, sel_exp);
    chk(addr_valid, sel_exp !== 5'h1F);
    if (sel_exp !== 5'h1F) chk(addr_out, a);
    chk(rom_hit, sp == SPACE_PROG && sel_exp === 5'h1F && !hold);
    acc.strobe = 1'b1;
    @(negedge clk);
    chk(ctrl, stb_exp);
    acc = '0;
    @(negedge clk);
    chk({addr_valid, ctrl}, {1'b0, 5'h1F});
  endtask : bus_access
  task automatic mode_write(input logic v);
    @(negedge clk);
    wr    = 1'b1;
    wdata = v;
    @(negedge clk);
    wr = 1'b0;
    chk(mode_reg, v);
  endtask : mode_write
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk({addr_valid, ctrl}, {1'b0, 5'h1F});
    chk(mode_reg, 1'b0);
  endtask : t_reset
  task automatic t_spaces;
    bus_access(SPACE_DATA, 23'h001234, 5'h17, 5'h15);
    bus_access(SPACE_IO, 23'h000056, 5'h1B, 5'h1A);
    bus_access(SPACE_PROG, 23'h7F0001, 5'h0F, 5'h0D);
    chk(mem_hits, 2);
    chk(io_hits, 1);
  endtask : t_spaces
  // pin moves after reset; rom range must still be served inside
  task automatic t_rom;
    mode_pin = 1'b1;
    repeat (6) @(negedge clk);
    chk(mode_reg, 1'b0);
    bus_access(SPACE_PROG, ROM_BASE, 5'h1F, 5'h1F);
    mode_write(1'b1);
    bus_access(SPACE_PROG, ROM_LAST, 5'h0F, 5'h0D);
    mode_write(1'b0);
    bus_access(SPACE_PROG, ROM_LAST, 5'h1F, 5'h1F);
  endtask : t_rom
  // float pin passes a 3-flop sync, so allow five cycles
  task automatic t_float;
    hold = 1'b1;
    @(negedge clk);
    chk({sel_oe, stb_oe}, 2'b00);
    bus_access(SPACE_DATA, 23'h000010, 5'h1F, 5'h1F);
    hold  = 1'b0;
    off_n = 1'b0;
    repeat (5) @(negedge clk);
    chk({sel_oe, stb_oe}, 2'b00);
    off_n = 1'b1;
    repeat (5) @(negedge clk);
    chk({sel_oe, stb_oe}, 2'b11);
  endtask : t_float
  // second reset with the pin high: microprocessor mode, rom range goes out
  task automatic t_rereset;
    srst = 1'b1;
    repeat (6) @(negedge clk);
    srst = 1'b0;
    chk(mode_reg, 1'b1);
    chk({addr_valid, ctrl}, {1'b0, 5'h1F});
    bus_access(SPACE_PROG, ROM_BASE, 5'h0F, 5'h0D);
    chk(mem_hits, 4);
    chk(io_hits, 1);
  endtask : t_rereset
  // hang guard well beyond the roughly 75 cycles the scenarios need
  initial begin
    #8000;
    errors++;
    end_sim();
  end
  initial begin
    {errors, check_count} = '0;
    {srst, mode_pin, off_n, hold, wr, wdata} = 6'b101000;
    acc = '0;
    repeat (16) @(negedge clk);
    srst = 1'b0;
    t_reset();
    t_spaces();
    t_rom();
    t_float();
    t_rereset();
    end_sim();
  end
endmodule : ext_bus_space_strobe_ctrl_bench
